// >>> verilog/ldmerge_pkg.sv
/*
  constants, instruction layout and carrier types for the load and
  bit-field merge execute block.
  assumes one 32-bit core clock domain shared with the data port.
*/
package ldmerge_pkg;

  // ****************************************************************
  // encoding
  // ****************************************************************
  localparam logic [3:0] OPC_LOADGRP = 4'h2;
  localparam logic [3:0] SUB_LDW     = 4'h2;
  localparam logic [3:0] SUB_LDHU    = 4'h5;
  localparam logic [3:0] SUB_MERGE   = 4'hf;
  localparam int         MSB_LO      = 5;
  localparam int         LSB_LO      = 0;
  localparam int         POS_W       = 5;
  localparam int         OFF_W       = 12;

  // ****************************************************************
  // sizes and reset values
  // ****************************************************************
  localparam int          REG_COUNT = 64;
  localparam int          IDX_W     = 6;
  localparam logic [31:0] REG_RST   = 32'h0;
  localparam logic [1:0]  WORD_MASK = 2'h3;
  localparam logic [15:0] HALF_ZERO = 16'h0;

  typedef struct packed {
    logic [3:0]       opcode;
    logic [IDX_W-1:0] reg_a;
    logic [IDX_W-1:0] reg_b;
    logic [3:0]       sub;
    logic [11:0]      offset_immediate;
  } instr_t;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
    logic        half;
  } mem_req_t;

  typedef struct packed {
    logic             valid;
    logic [IDX_W-1:0] idx;
    logic [31:0]      data;
  } wb_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } state_t;

endpackage

// >>> verilog/bit_merge.sv
/*
  combinational splice of a bit range from a source word into a
  destination word, with no shift.
  assumes msb and lsb are 5-bit unsigned positions.
*/
`timescale 1ns/1ps
module bit_merge
  import ldmerge_pkg::*;
(
  input  wire logic [31:0]      dst,
  input  wire logic [31:0]      src,
  input  wire logic [POS_W-1:0] msb,
  input  wire logic [POS_W-1:0] lsb,
  output logic      [31:0]      result
);

  logic [31:0] mask;

  // msb below lsb gives an empty mask
  assign mask = (32'hffffffff << lsb) &
                (32'hffffffff >> (5'd31 - msb));

  assign result = (dst & ~mask) | (src & mask);

endmodule

// >>> verilog/ldmerge_exec.sv
/*
  decode and execute of the unsigned halfword load, the word load and
  the bit-field merge, with the register file held here.
  assumes a data port partner that answers each held request with one
  mem_rvalid pulse carrying a full aligned word, on the same clock.
*/
`timescale 1ns/1ps
module ldmerge_exec
  import ldmerge_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        instr_valid,
  input  wire instr_t      instr,
  output logic             instr_ready_q,
  output mem_req_t         mem_q,
  input  wire logic        mem_rvalid,
  input  wire logic [31:0] mem_rdata,
  output wb_t              wb_q,
  output logic             illegal_q
);

  // ****************************************************************
  // decode
  // ****************************************************************
  logic [31:0]      regs [REG_COUNT];
  state_t           st_q;
  logic [IDX_W-1:0] pend_idx_q;
  logic             pend_ldhu_q;
  logic             accept;
  logic             is_grp;
  logic             is_ldw;
  logic             is_ldhu;
  logic             is_merge;
  logic [31:0]      opa;
  logic [31:0]      opb;
  logic [31:0]      offset_ext;
  logic [31:0]      ea;
  logic [31:0]      merge_res;
  logic [15:0]      half;
  logic             load_done;
  wb_t              wb_d;

  assign accept   = instr_valid && instr_ready_q;
  assign is_grp   = instr.opcode == OPC_LOADGRP;
  assign is_ldw   = is_grp && instr.sub == SUB_LDW;
  assign is_ldhu  = is_grp && instr.sub == SUB_LDHU;
  assign is_merge = is_grp && instr.sub == SUB_MERGE;

  assign opa = regs[instr.reg_a];
  assign opb = regs[instr.reg_b];

  assign offset_ext = {{(32-OFF_W){instr.offset_immediate[OFF_W-1]}},
                       instr.offset_immediate};
  assign ea = opa + offset_ext;

  // ****************************************************************
  // merge datapath
  // ****************************************************************
  bit_merge u_merge (
    .dst    (opa),
    .src    (opb),
    .msb    (instr.offset_immediate[MSB_LO +: POS_W]),
    .lsb    (instr.offset_immediate[LSB_LO +: POS_W]),
    .result (merge_res)
  );

  // ****************************************************************
  // load sequencing
  // ****************************************************************
  assign load_done = st_q == ST_WAIT && mem_rvalid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (accept && (is_ldw || is_ldhu)) begin
            st_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (mem_rvalid) begin
            st_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      instr_ready_q <= 1'b0;
    end else begin
      instr_ready_q <= st_q == ST_IDLE ? !(accept && (is_ldw || is_ldhu))
                                        : mem_rvalid;
    end
  end

  // low address bits dropped, word aligned fetch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_q       <= '0;
      pend_idx_q  <= '0;
      pend_ldhu_q <= 1'b0;
    end else if (accept && (is_ldw || is_ldhu)) begin
      mem_q.req   <= 1'b1;
      mem_q.addr  <= {ea[31:2], 2'b00};
      mem_q.half  <= ea[1];
      pend_idx_q  <= instr.reg_b;
      pend_ldhu_q <= is_ldhu;
    end else if (load_done) begin
      mem_q.req   <= 1'b0;
    end
  end

  // ****************************************************************
  // write back and register file
  // ****************************************************************
  // halfword lane from the fetched word
  assign half = mem_q.half ? mem_rdata[31:16] : mem_rdata[15:0];

  always_comb begin
    wb_d = '0;
    if (accept && is_merge) begin
      wb_d.valid = 1'b1;
      wb_d.idx   = instr.reg_a;
      wb_d.data  = merge_res;
    end else if (load_done) begin
      wb_d.valid = 1'b1;
      wb_d.idx   = pend_idx_q;
      wb_d.data  = pend_ldhu_q ? {HALF_ZERO, half} : mem_rdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_q      <= '0;
      illegal_q <= 1'b0;
    end else begin
      wb_q      <= wb_d;
      illegal_q <= accept && !(is_ldw || is_ldhu || is_merge);
    end
  end

  // register zero stays hardwired to zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= REG_RST;
      end
    end else if (wb_d.valid && wb_d.idx != '0) begin
      regs[wb_d.idx] <= wb_d.data;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [31:0] ref_mask;
  assign ref_mask = (32'hffffffff << instr.offset_immediate[4:0]) &
                    (32'hffffffff >> (5'd31 - instr.offset_immediate[9:5]));

  sequence load_taken_s;
    accept && (is_ldw || is_ldhu);
  endsequence

  sequence load_back_s;
    st_q == ST_WAIT && mem_rvalid;
  endsequence

  ea_sum_a: assert property (
    load_taken_s |=> mem_q.req && mem_q.addr[31:2] ==
      $past(opa + {{20{instr.offset_immediate[11]}},
                   instr.offset_immediate}) >> 2)
    else $error("load address not base plus offset");

  neg_offset_a: assert property (
    (load_taken_s and
     (instr.offset_immediate[11] && opa[31:12] != '0))
    |=> mem_q.addr[31:12] <= $past(opa[31:12]))
    else $error("negative offset not subtracted");

  half_zero_a: assert property (
    (load_back_s and pend_ldhu_q) |=> wb_q.valid && wb_q.data[31:16] == '0
      && wb_q.data[15:0] == $past(half))
    else $error("halfword load not zero extended");

  word_pass_a: assert property (
    (load_back_s and !pend_ldhu_q) |=> wb_q.valid &&
      wb_q.data == $past(mem_rdata) && wb_q.idx == $past(pend_idx_q))
    else $error("word load data altered");

  decode_grp_a: assert property (
    accept && instr.opcode != OPC_LOADGRP
    |=> illegal_q && !wb_q.valid && !mem_q.req)
    else $error("foreign opcode executed");

  merge_body_a: assert property (
    accept && is_merge |=> wb_q.valid && wb_q.idx == $past(instr.reg_a)
      && wb_q.data == (($past(opa) & ~$past(ref_mask)) |
                       ($past(opb) & $past(ref_mask))))
    else $error("merge result wrong");

  merge_noshift_a: assert property (
    accept && is_merge && instr.offset_immediate[9:5] ==
      instr.offset_immediate[4:0]
    |=> wb_q.data[$past(instr.offset_immediate[4:0])] ==
        $past(opb[instr.offset_immediate[4:0]]))
    else $error("merge bit moved");

  merge_sub_a: assert property (
    accept && is_grp && instr.sub == SUB_MERGE |=> instr_ready_q)
    else $error("merge stalled");

  zero_clear_a: assert property (
    accept && is_merge && instr.reg_b == '0
    |=> (wb_q.data & $past(ref_mask)) == '0)
    else $error("zero source did not clear range");

  no_hang_a: assert property (
    load_back_s |-> mem_q.addr[1:0] == '0 ##1
      (instr_ready_q && !mem_q.req))
    else $error("load did not release");

  bad_range_a: assert property (
    accept && is_merge && instr.offset_immediate[9:5] <
      instr.offset_immediate[4:0]
    |=> wb_q.data == $past(opa) && instr_ready_q)
    else $error("inverted range not stable");

endmodule

// >>> bench/mem_model.sv
/*
  data port memory model: one word per held request.
  assumes the block holds req until the cycle after rvalid.
*/
`timescale 1ns/1ps
module mem_model
  import ldmerge_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire mem_req_t   mem,
  input  wire logic [3:0] lat,
  output logic            rvalid_q,
  output logic [31:0]     rdata_q
);
  // ****************************************************************
  // answer after lat waiting cycles
  // ****************************************************************
  logic [3:0] cnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h5a5a_5a5a;
      cnt_q    <= 4'h0;
    end else if (mem.req && !rvalid_q && cnt_q == lat) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {~mem.addr[15:0], mem.addr[15:0]};
      cnt_q    <= 4'h0;
    end else begin
      // data toggles when not valid
      rvalid_q <= 1'b0;
      rdata_q  <= ~rdata_q;
      cnt_q    <= (mem.req && !rvalid_q) ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule

// >>> bench/load_and_bitfield_merge_exec_tb.sv
/*
  bench for the load and merge block.
  assumes mem_model on the data port.
*/
`timescale 1ns/1ps
module load_and_bitfield_merge_exec_tb
  import ldmerge_pkg::*;
;
  logic        clk;
  logic        rst;
  logic        instr_valid;
  instr_t      instr;
  logic        instr_ready_q;
  mem_req_t    mem_q;
  logic        mem_rvalid;
  logic [31:0] mem_rdata;
  wb_t         wb_q;
  logic        illegal_q;
  logic [3:0]  lat;
  logic [31:0] sh [REG_COUNT];
  int          n_fail;
  int          checks_done;

  ldmerge_exec dut (.clk(clk), .rst(rst), .instr_valid(instr_valid),
    .instr(instr), .instr_ready_q(instr_ready_q), .mem_q(mem_q),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .wb_q(wb_q),
    .illegal_q(illegal_q));
  mem_model mem (.clk(clk), .rst(rst), .mem(mem_q), .lat(lat),
    .rvalid_q(mem_rvalid), .rdata_q(mem_rdata));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] word_at(logic [31:0] a);
    logic [15:0] lo;
    lo = {a[15:2], 2'h0};
    return {~lo, lo};
  endfunction

  function automatic instr_t mk(logic [3:0] s, int a, int b,
                                logic [11:0] imm);
    return {OPC_LOADGRP, a[5:0], b[5:0], s, imm};
  endfunction

  task automatic chk(logic [39:0] got, logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic exec(instr_t ins, logic [31:0] ea, logic [31:0] d,
                      logic bad);
    int          n;
    logic [5:0]  ix;
    ix = (ins.sub == SUB_MERGE) ? ins.reg_a : ins.reg_b;
    n = 0;
    @(negedge clk);
    instr_valid = 1'b1;
    instr = ins;
    while (instr_ready_q !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    instr_valid = 1'b0;
    if (!bad && ins.sub != SUB_MERGE)
      chk({mem_q.req, mem_q.addr}, {1'b1, ea[31:2], 2'h0});
    n = 0;
    while (wb_q.valid !== 1'b1 && illegal_q !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk(wb_q.valid | illegal_q, 1'b1);
    chk(illegal_q, bad);
    if (!bad) begin
      chk({wb_q.idx, wb_q.data}, {ix, d});
      sh[ix] = d;
    end
  endtask

  task automatic do_mg(int a, int b, logic [4:0] hi, logic [4:0] lo);
    logic [31:0] m;
    m = (32'hffff_ffff >> (5'd31 - hi)) & (32'hffff_ffff << lo);
    if (hi < lo) m = 32'h0;
    exec(mk(SUB_MERGE, a, b, {2'h0, hi, lo}), 0,
         (sh[a] & ~m) | (sh[b] & m), 1'b0);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_loads;
    logic [31:0] ea;
    logic [31:0] w;
    lat = 4'h0;
    exec(mk(SUB_LDW, 0, 5, 12'h100), 32'h100, word_at(32'h100), 0);
    lat = 4'h6;
    ea = sh[5] + 32'hffff_ff24;
    exec(mk(SUB_LDW, 5, 6, 12'hf24), ea, word_at(ea), 0);
    ea = sh[5] + 32'h2;
    w = word_at(ea);
    exec(mk(SUB_LDHU, 5, 40, 12'h002), ea, {16'h0, w[31:16]}, 0);
    lat = 4'h1;
    ea = sh[5] + 32'h7fc;
    w = word_at(ea);
    exec(mk(SUB_LDHU, 5, 41, 12'h7fc), ea, {16'h0, w[15:0]}, 0);
    ea = sh[5] + 32'h3;
    exec(mk(SUB_LDW, 5, 7, 12'h003), ea, word_at(ea), 0);
    $display("test loads done");
  endtask

  task automatic t_merge;
    do_mg(6, 5, 5'd22, 5'd10);
    do_mg(6, 0, 5'd15, 5'd4);
    do_mg(5, 6, 5'd3, 5'd9);
    do_mg(40, 5, 5'd31, 5'd0);
    do_mg(40, 6, 5'd7, 5'd7);
    $display("test merge done");
  endtask

  task automatic t_bad;
    instr_t ins;
    ins = mk(SUB_LDW, 5, 6, 12'h0);
    ins.opcode = 4'h3;
    exec(ins, 0, 0, 1'b1);
    exec(mk(4'h4, 5, 6, 12'h0), 0, 0, 1'b1);
    do_mg(41, 6, 5'd31, 5'd0);
    $display("test illegal done");
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #60000;
    n_fail++;
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    instr_valid = 1'b0;
    instr = '0;
    lat = 4'h0;
    n_fail = 0;
    checks_done = 0;
    foreach (sh[i]) sh[i] = REG_RST;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_loads();
    t_merge();
    t_bad();
    end_of_test();
  end
endmodule
